// *** pfr_board_model.sv ***
// board and test host side of the pad group, resolving each wire level
`timescale 1ns/10ps
module pfr_board_model (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic [6:0] pad_o_i,
	input wire logic [6:0] pad_oe_n_i,
	input wire logic [6:0] pullup_i,
	input wire logic [6:0] drive_i,
	input wire logic [6:0] drive_en_i,
	output logic [6:0] level_o
);
	logic float_q;
	// a floating pin shows a changing level, never a stale one
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) float_q <= 1'b0;
		else float_q <= ~float_q;
	end
	// a low driver wins, as on the open-drain reset line
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			if (!pad_oe_n_i[i]) level_o[i] = pad_o_i[i] & (drive_i[i] | !drive_en_i[i]);
			else if (drive_en_i[i]) level_o[i] = drive_i[i];
			else level_o[i] = pullup_i[i] | float_q;
		end
	end
endmodule : pfr_board_model

// *** pfr_pin_mux.sv ***
// pin function multiplexer with reset pin handling and reset release
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps

// Overview of operation
// - port_b_line_7 comes up as port line
// - reset pin low holds chip in reset
// - internal reset released synchronously after fixed count
// - port_a_line_7 only input or open drain
// - pin reset ignored while pin is port
// - shared reset pin defaults to reset function
// - clock output picks off, master, bus, oscillator
// - port_b lines 4 and 5 default port
// - selected fault input disables chosen pwm outputs
// - mode select sampled on test clock rise
// - test data sampled on test clock rise
// - test pins default to test functions
// - each port line has own direction
module pfr_pin_mux #(
	parameter int NUM_PADS = pfr_pkg::NUM_PADS,
	parameter int PWM_CH = pfr_pkg::PWM_CH,
	parameter int RESET_HOLD_CYCLES = pfr_pkg::RESET_HOLD_CYCLES,
	parameter logic FAULT_ACTIVE_HIGH = 1'b1
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// register port
	input wire logic [pfr_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [pfr_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [pfr_pkg::DATA_W-1:0] reg_rdata_o,
	// other reset sources
	input wire logic watchdog_reset_i,
	input wire logic software_reset_i,
	output logic chip_reset_o,
	// pads
	input wire logic [NUM_PADS-1:0] pad_i,
	output logic [NUM_PADS-1:0] pad_o,
	output logic [NUM_PADS-1:0] pad_oe_n_o,
	output logic [NUM_PADS-1:0] pad_pullup_o,
	// alternate peripheral on port_b_line_7
	input wire logic b7_alt_out_i,
	input wire logic b7_alt_oe_i,
	output logic b7_alt_in_o,
	// timer channels
	input wire logic timer0_out_i,
	input wire logic timer0_oe_i,
	output logic timer0_in_o,
	input wire logic timer1_out_i,
	input wire logic timer1_oe_i,
	output logic timer1_in_o,
	// clock output sources
	input wire logic master_clk_i,
	input wire logic bus_clk_i,
	input wire logic osc_clk_i,
	// fault to pwm
	output logic [PWM_CH-1:0] pwm_disable_o,
	// test access port
	output logic tap_tck_o,
	output logic tap_tms_o,
	output logic tap_tdi_o
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------

	// push-pull port line: enable is low while driving
	function automatic logic drive_n(input logic dir);
		drive_n = ~dir;
	endfunction : drive_n

	// open drain: only a low level is ever driven
	function automatic logic od_drive_n(input logic dir, input logic val);
		od_drive_n = ~(dir & ~val);
	endfunction : od_drive_n

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [pfr_pkg::FS_W-1:0] func_q;
	logic [1:0] clock_output_pin_sel_q;
	logic [NUM_PADS-1:0] gpio_dir_q;
	logic [NUM_PADS-1:0] gpio_out_q;
	logic [NUM_PADS-1:0] gpio_in_q;
	logic [PWM_CH-1:0] fault_mask_q;
	logic [pfr_pkg::HOLD_CNT_W-1:0] hold_cnt_q;
	logic chip_reset_q;
	logic pin_reset_seen_q;
	logic clock_output_pin_q;
	logic fault_q;
	logic [NUM_PADS-1:0] pad_d;
	logic [NUM_PADS-1:0] oe_n_d;
	logic [NUM_PADS-1:0] pu_d;
	logic pin_reset;
	logic reset_req;
	logic clock_output_pin_d;
	logic fault_level;
	logic [1:0] b4_sel;
	logic [1:0] b5_sel;
	logic [pfr_pkg::DATA_W-1:0] rdata_d;

	localparam logic [pfr_pkg::HOLD_CNT_W-1:0] HOLD_LOAD =
		pfr_pkg::HOLD_CNT_W'(RESET_HOLD_CYCLES - 1);

	assign b4_sel = func_q[pfr_pkg::FS_B4_LSB +: 2];
	assign b5_sel = func_q[pfr_pkg::FS_B5_LSB +: 2];

	// ------------------------------------------------------------
	// reset generation
	// ------------------------------------------------------------

	// pin counts as reset only while it has the reset function
	assign pin_reset = ~func_q[pfr_pkg::FS_A7_GPIO] & ~pad_i[pfr_pkg::PAD_A7];
	assign reset_req = pin_reset | watchdog_reset_i | software_reset_i;

	// hold reset while any source is active, then count down on the clock;
	// the release is thus always aligned to ref_clk_i
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			hold_cnt_q <= HOLD_LOAD;
			chip_reset_q <= 1'b1;
		end else if (reset_req) begin
			hold_cnt_q <= HOLD_LOAD;
			chip_reset_q <= 1'b1;
		end else if (hold_cnt_q != '0) begin
			hold_cnt_q <= hold_cnt_q - 1'b1;
		end else begin
			chip_reset_q <= 1'b0;
		end
	end

	assign chip_reset_o = chip_reset_q;

	// sticky record that the pin caused a reset; cleared by a status read
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pin_reset_seen_q <= 1'b0;
		end else if (pin_reset) begin
			pin_reset_seen_q <= 1'b1; // set wins over the read clear
		end else if (reg_read_i && reg_addr_i == pfr_pkg::REG_STATUS) begin
			pin_reset_seen_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------

	// every internal reset returns all pins to their defaults; writes made
	// while the chip is held in reset are dropped on purpose
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			func_q <= pfr_pkg::FS_RESET;
		end else if (chip_reset_q) begin
			func_q <= pfr_pkg::FS_RESET;
		end else if (reg_write_i && reg_addr_i == pfr_pkg::REG_FUNC_SEL) begin
			func_q <= reg_wdata_i[pfr_pkg::FS_W-1:0];
		end
	end

	// clock output source select
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			clock_output_pin_sel_q <= pfr_pkg::CLOCK_OUTPUT_PIN_SEL_RESET;
		end else if (chip_reset_q) begin
			clock_output_pin_sel_q <= pfr_pkg::CLOCK_OUTPUT_PIN_SEL_RESET;
		end else if (reg_write_i && reg_addr_i == pfr_pkg::REG_CLOCK_OUTPUT_PIN_SEL) begin
			clock_output_pin_sel_q <= reg_wdata_i[1:0];
		end
	end

	// direction and output data, one bit per line
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			gpio_dir_q <= pfr_pkg::GPIO_DIR_RESET;
			gpio_out_q <= pfr_pkg::GPIO_OUT_RESET;
		end else if (chip_reset_q) begin
			gpio_dir_q <= pfr_pkg::GPIO_DIR_RESET;
			gpio_out_q <= pfr_pkg::GPIO_OUT_RESET;
		end else if (reg_write_i && reg_addr_i == pfr_pkg::REG_GPIO_DIR) begin
			gpio_dir_q <= reg_wdata_i[NUM_PADS-1:0];
		end else if (reg_write_i && reg_addr_i == pfr_pkg::REG_GPIO_OUT) begin
			gpio_out_q <= reg_wdata_i[NUM_PADS-1:0];
		end
	end

	// pwm channels shut down by the off-chip fault
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			fault_mask_q <= '0;
		end else if (chip_reset_q) begin
			fault_mask_q <= '0;
		end else if (reg_write_i && reg_addr_i == pfr_pkg::REG_FAULT_MASK) begin
			fault_mask_q <= reg_wdata_i[PWM_CH-1:0];
		end
	end

	// ------------------------------------------------------------
	// register read back
	// ------------------------------------------------------------

	// decode of the read address; unmapped offsets answer zero
	always_comb begin
		rdata_d = '0;
		if (reg_addr_i == pfr_pkg::REG_FUNC_SEL) begin
			rdata_d[pfr_pkg::FS_W-1:0] = func_q;
		end else if (reg_addr_i == pfr_pkg::REG_CLOCK_OUTPUT_PIN_SEL) begin
			rdata_d[1:0] = clock_output_pin_sel_q;
		end else if (reg_addr_i == pfr_pkg::REG_GPIO_DIR) begin
			rdata_d[NUM_PADS-1:0] = gpio_dir_q;
		end else if (reg_addr_i == pfr_pkg::REG_GPIO_OUT) begin
			rdata_d[NUM_PADS-1:0] = gpio_out_q;
		end else if (reg_addr_i == pfr_pkg::REG_GPIO_IN) begin
			rdata_d[NUM_PADS-1:0] = gpio_in_q;
		end else if (reg_addr_i == pfr_pkg::REG_FAULT_MASK) begin
			rdata_d[PWM_CH-1:0] = fault_mask_q;
		end else if (reg_addr_i == pfr_pkg::REG_STATUS) begin
			rdata_d[1:0] = {pin_reset_seen_q, fault_q};
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			reg_rdata_o <= '0;
		end else if (reg_read_i) begin
			reg_rdata_o <= rdata_d;
		end else begin
			reg_rdata_o <= '0;
		end
	end

	// ------------------------------------------------------------
	// clock output and fault
	// ------------------------------------------------------------

	// source select; off holds the pin at zero
	always_comb begin
		case (clock_output_pin_sel_q)
			pfr_pkg::PFR_CLOCK_OUTPUT_PIN_MASTER: clock_output_pin_d = master_clk_i;
			pfr_pkg::PFR_CLOCK_OUTPUT_PIN_BUS: clock_output_pin_d = bus_clk_i;
			pfr_pkg::PFR_CLOCK_OUTPUT_PIN_OSC: clock_output_pin_d = osc_clk_i;
			default: clock_output_pin_d = 1'b0;
		endcase
	end

	// fault counts only while the pad carries the fault function
	assign fault_level = (b5_sel == pfr_pkg::PFR_B5_FAULT) &&
		(pad_i[pfr_pkg::PAD_B5] == FAULT_ACTIVE_HIGH);

	// registered so the sources reach the pad glitch free, at one cycle cost
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			clock_output_pin_q <= 1'b0;
			fault_q <= 1'b0;
			pwm_disable_o <= '0;
		end else begin
			clock_output_pin_q <= clock_output_pin_d;
			fault_q <= fault_level;
			pwm_disable_o <= {PWM_CH{fault_level}} & fault_mask_q;
		end
	end

	// ------------------------------------------------------------
	// pad drive
	// ------------------------------------------------------------

	// port function first, then alternates override per pad
	always_comb begin
		pad_d = gpio_out_q;
		for (int i = 0; i < NUM_PADS; i++) begin
			oe_n_d[i] = drive_n(gpio_dir_q[i]);
		end
		// reset pin or open drain port line, never push-pull
		pad_d[pfr_pkg::PAD_A7] = 1'b0;
		oe_n_d[pfr_pkg::PAD_A7] = od_drive_n(gpio_dir_q[pfr_pkg::PAD_A7],
			gpio_out_q[pfr_pkg::PAD_A7]);
		if (!func_q[pfr_pkg::FS_A7_GPIO]) begin
			oe_n_d[pfr_pkg::PAD_A7] = 1'b1;
		end
		if (func_q[pfr_pkg::FS_B7_ALT]) begin
			pad_d[pfr_pkg::PAD_B7] = b7_alt_out_i;
			oe_n_d[pfr_pkg::PAD_B7] = ~b7_alt_oe_i;
		end
		case (b4_sel)
			pfr_pkg::PFR_B4_TIMER0: begin
				pad_d[pfr_pkg::PAD_B4] = timer0_out_i;
				oe_n_d[pfr_pkg::PAD_B4] = ~timer0_oe_i;
			end
			pfr_pkg::PFR_B4_CLOCK_OUTPUT_PIN: begin
				pad_d[pfr_pkg::PAD_B4] = clock_output_pin_q;
				oe_n_d[pfr_pkg::PAD_B4] = 1'b0;
			end
			default: begin
			end
		endcase
		case (b5_sel)
			pfr_pkg::PFR_B5_TIMER1: begin
				pad_d[pfr_pkg::PAD_B5] = timer1_out_i;
				oe_n_d[pfr_pkg::PAD_B5] = ~timer1_oe_i;
			end
			pfr_pkg::PFR_B5_FAULT: begin
				oe_n_d[pfr_pkg::PAD_B5] = 1'b1;
			end
			default: begin
			end
		endcase
		// test pins are inputs unless handed to the port
		if (!func_q[pfr_pkg::FS_D2_GPIO]) begin
			oe_n_d[pfr_pkg::PAD_D2] = 1'b1;
		end
		if (!func_q[pfr_pkg::FS_D3_GPIO]) begin
			oe_n_d[pfr_pkg::PAD_D3] = 1'b1;
		end
		if (!func_q[pfr_pkg::FS_D0_GPIO]) begin
			oe_n_d[pfr_pkg::PAD_D0] = 1'b1;
		end
		// pull-up whenever nobody drives the pad
		pu_d = oe_n_d;
		if (chip_reset_q) begin
			pad_d = '0;
			oe_n_d = '1;
			pu_d = '1;
		end
	end

	// pad outputs held in flops so reset values are clean
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pad_o <= '0;
			pad_oe_n_o <= '1;
			pad_pullup_o <= '1;
		end else begin
			pad_o <= pad_d;
			pad_oe_n_o <= oe_n_d;
			pad_pullup_o <= pu_d;
		end
	end

	// ------------------------------------------------------------
	// inputs towards peripherals
	// ------------------------------------------------------------

	// unselected b7 and tap inputs rest at the pulled-up level so the tap stays idle, timer inputs rest low;
	// tck is only sampled here, the tap itself sees the edges one cycle late
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			gpio_in_q <= '0;
			b7_alt_in_o <= 1'b1;
			timer0_in_o <= 1'b0;
			timer1_in_o <= 1'b0;
			tap_tck_o <= 1'b1;
			tap_tms_o <= 1'b1;
			tap_tdi_o <= 1'b1;
		end else begin
			gpio_in_q <= pad_i;
			b7_alt_in_o <= func_q[pfr_pkg::FS_B7_ALT] ? pad_i[pfr_pkg::PAD_B7] : 1'b1;
			timer0_in_o <= (b4_sel == pfr_pkg::PFR_B4_TIMER0) & pad_i[pfr_pkg::PAD_B4];
			timer1_in_o <= (b5_sel == pfr_pkg::PFR_B5_TIMER1) & pad_i[pfr_pkg::PAD_B5];
			tap_tck_o <= func_q[pfr_pkg::FS_D2_GPIO] | pad_i[pfr_pkg::PAD_D2];
			tap_tms_o <= func_q[pfr_pkg::FS_D3_GPIO] | pad_i[pfr_pkg::PAD_D3];
			tap_tdi_o <= func_q[pfr_pkg::FS_D0_GPIO] | pad_i[pfr_pkg::PAD_D0];
		end
	end

endmodule : pfr_pin_mux

// *** pfr_pin_mux_monitor.sv ***
// concurrent checks on the pin function and reset multiplexer ports
`timescale 1ns/10ps
module pfr_pin_mux_monitor #(
	parameter int NUM_PADS = 7,
	parameter int PWM_CH = 6,
	parameter int RESET_HOLD_CYCLES = 32
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic watchdog_reset_i,
	input wire logic software_reset_i,
	input wire logic chip_reset_o,
	input wire logic [NUM_PADS-1:0] pad_i,
	input wire logic [NUM_PADS-1:0] pad_o,
	input wire logic [NUM_PADS-1:0] pad_oe_n_o,
	input wire logic [NUM_PADS-1:0] pad_pullup_o,
	input wire logic master_clk_i,
	input wire logic bus_clk_i,
	input wire logic osc_clk_i,
	input wire logic [PWM_CH-1:0] pwm_disable_o,
	input wire logic tap_tck_o,
	input wire logic tap_tms_o,
	input wire logic tap_tdi_o
);
	logic [15:0] rf_q [6];
	int quiet_q;
	logic pin_req;
	logic src_d;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	// ------------------------------------------------------------
	// helper logic
	// ------------------------------------------------------------
	// register mirror, cleared while chip reset blocks writes
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) rf_q <= '{default: '0};
		else if (chip_reset_o) rf_q <= '{default: '0};
		else if (reg_write_i && reg_addr_i < 4'h6) rf_q[reg_addr_i] <= reg_wdata_i;
	end
	assign pin_req = !pad_i[1] && !rf_q[0][1];
	// edges since the last reset request, saturating so it never wraps
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) quiet_q <= 0;
		else if (pin_req || watchdog_reset_i || software_reset_i) quiet_q <= 0;
		else if (quiet_q < 1000) quiet_q <= quiet_q + 1;
	end
	// clock output source chosen by the select register
	always_comb begin
		case (rf_q[1][1:0])
			2'b00: src_d = 1'b0;
			2'b01: src_d = master_clk_i;
			2'b10: src_d = bus_clk_i;
			default: src_d = osc_clk_i;
		endcase
	end
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_reset_held;
		chip_reset_o[*3];
	endsequence
	sequence s_clock_output_pin_held;
		(rf_q[0][3:2] == 2'b10 && !chip_reset_o && $stable(rf_q[1]))[*3];
	endsequence
	AST_PIN_RESET: assert property (pin_req |=> chip_reset_o)
		else $error("reset pin low did not start chip reset");
	AST_PIN_IGNORED: assert property (!chip_reset_o && rf_q[0][1] && !watchdog_reset_i
		&& !software_reset_i |=> !chip_reset_o) else $error("port line caused a reset");
	AST_RELEASE: assert property (chip_reset_o == (quiet_q < RESET_HOLD_CYCLES))
		else $error("chip reset release count wrong");
	AST_RESET_PADS: assert property (s_reset_held |-> &pad_oe_n_o && &pad_pullup_o)
		else $error("pad driven or pull-up off in reset");
	AST_PORT_DIR: assert property (!chip_reset_o && !rf_q[0][0] |=> pad_oe_n_o[0] ==
		!$past(rf_q[2][0]) && (pad_oe_n_o[0] || pad_o[0] == $past(rf_q[3][0])))
		else $error("port line direction or value wrong");
	AST_A7_OPEN_DRAIN: assert property (!pad_oe_n_o[1] |-> !pad_o[1])
		else $error("reset pin line driven high");
	AST_CLOCK_OUTPUT_PIN: assert property (s_clock_output_pin_held |-> !pad_oe_n_o[2] && pad_o[2] == $past(src_d, 2))
		else $error("clock output source wrong");
	AST_FAULT: assert property (!chip_reset_o |=> pwm_disable_o ==
		($past(rf_q[0][5:4] == 2'b10 && pad_i[3]) ? $past(rf_q[5][5:0]) : 6'h00))
		else $error("pwm disable does not follow fault");
	AST_TAP: assert property (!chip_reset_o |=> {tap_tdi_o, tap_tms_o, tap_tck_o} ==
		($past(pad_i[6:4]) | $past(rf_q[0][8:6]))) else $error("test port input wrong");
endmodule : pfr_pin_mux_monitor

bind pfr_pin_mux pfr_pin_mux_monitor #(.NUM_PADS(NUM_PADS), .PWM_CH(PWM_CH),
	.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) i_monitor (.ref_clk_i, .reset_i, .reg_addr_i,
	.reg_wdata_i, .reg_write_i, .watchdog_reset_i, .software_reset_i, .chip_reset_o, .pad_i,
	.pad_o, .pad_oe_n_o, .pad_pullup_o, .master_clk_i, .bus_clk_i, .osc_clk_i, .pwm_disable_o,
	.tap_tck_o, .tap_tms_o, .tap_tdi_o);

// *** pfr_pkg.sv ***
// constants shared by the pin function and reset multiplexer
package pfr_pkg;

	// ------------------------------------------------------------
	// pad indices of the multiplexed pin group
	// ------------------------------------------------------------
	localparam int NUM_PADS = 7;
	localparam int PAD_B7 = 0; // port_b_line_7
	localparam int PAD_A7 = 1; // reset pin / port_a_line_7
	localparam int PAD_B4 = 2; // port_b_line_4
	localparam int PAD_B5 = 3; // port_b_line_5
	localparam int PAD_D2 = 4; // test clock / port_d_line_2
	localparam int PAD_D3 = 5; // mode select / port_d_line_3
	localparam int PAD_D0 = 6; // test data in / port_d_line_0

	// ------------------------------------------------------------
	// register bus layout
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [3:0] REG_FUNC_SEL = 4'h0;
	localparam logic [3:0] REG_CLOCK_OUTPUT_PIN_SEL = 4'h1;
	localparam logic [3:0] REG_GPIO_DIR = 4'h2;
	localparam logic [3:0] REG_GPIO_OUT = 4'h3;
	localparam logic [3:0] REG_GPIO_IN = 4'h4;
	localparam logic [3:0] REG_FAULT_MASK = 4'h5;
	localparam logic [3:0] REG_STATUS = 4'h6;

	// function select field positions
	localparam int FS_B7_ALT = 0;
	localparam int FS_A7_GPIO = 1;
	localparam int FS_B4_LSB = 2;
	localparam int FS_B5_LSB = 4;
	localparam int FS_D2_GPIO = 6;
	localparam int FS_D3_GPIO = 7;
	localparam int FS_D0_GPIO = 8;
	localparam int FS_W = 9;
	localparam logic [FS_W-1:0] FS_RESET = 9'h000;

	// ------------------------------------------------------------
	// encodings and reset values
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PFR_B4_GPIO = 2'b00,
		PFR_B4_TIMER0 = 2'b01,
		PFR_B4_CLOCK_OUTPUT_PIN = 2'b10
	} pfr_b4_sel_e;

	typedef enum logic [1:0] {
		PFR_B5_GPIO = 2'b00,
		PFR_B5_TIMER1 = 2'b01,
		PFR_B5_FAULT = 2'b10
	} pfr_b5_sel_e;

	typedef enum logic [1:0] {
		PFR_CLOCK_OUTPUT_PIN_OFF = 2'b00,
		PFR_CLOCK_OUTPUT_PIN_MASTER = 2'b01,
		PFR_CLOCK_OUTPUT_PIN_BUS = 2'b10,
		PFR_CLOCK_OUTPUT_PIN_OSC = 2'b11
	} pfr_clock_output_pin_sel_e;

	localparam logic [1:0] CLOCK_OUTPUT_PIN_SEL_RESET = 2'b00;
	localparam logic [6:0] GPIO_DIR_RESET = 7'h00;
	localparam logic [6:0] GPIO_OUT_RESET = 7'h00;
	localparam int PWM_CH = 6;
	localparam int RESET_HOLD_CYCLES = 32;
	localparam int HOLD_CNT_W = 6;

endpackage : pfr_pkg

// *** pin_function_reset_mux_tb.sv ***
// self-checking bench for the pin function and reset multiplexer
`timescale 1ns/10ps
module pin_function_reset_mux_tb;
	logic ref_clk_i = 1'b0, reset_i = 1'b1, alt = 1'b0;
	logic [3:0] reg_addr_i = 4'h0;
	logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o;
	logic reg_write_i = 1'b0, reg_read_i = 1'b0, watchdog_reset_i = 1'b0, software_reset_i = 1'b0;
	logic chip_reset_o, b7_alt_in_o, timer0_in_o, timer1_in_o, tap_tck_o, tap_tms_o, tap_tdi_o;
	logic [6:0] pad_i, pad_o, pad_oe_n_o, pad_pullup_o;
	logic [6:0] drv = 7'h00, drv_en = 7'h00;
	logic [5:0] pwm_disable_o;
	logic [2:0] src = 3'h0;
	int error_cnt = 0, check_count = 0;
	// short hold count keeps the reset waits brief
	pfr_pin_mux #(.RESET_HOLD_CYCLES(2)) i_dut (.ref_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i,
		.reg_write_i, .reg_read_i, .reg_rdata_o, .watchdog_reset_i, .software_reset_i,
		.chip_reset_o, .pad_i, .pad_o, .pad_oe_n_o, .pad_pullup_o, .b7_alt_out_i(alt),
		.b7_alt_oe_i(alt), .b7_alt_in_o, .timer0_out_i(alt), .timer0_oe_i(alt), .timer0_in_o,
		.timer1_out_i(alt), .timer1_oe_i(alt), .timer1_in_o, .master_clk_i(src[0]),
		.bus_clk_i(src[1]), .osc_clk_i(src[2]), .pwm_disable_o, .tap_tck_o, .tap_tms_o, .tap_tdi_o);
	pfr_board_model i_board (.ref_clk_i, .reset_i, .pad_o_i(pad_o), .pad_oe_n_i(pad_oe_n_o),
		.pullup_i(pad_pullup_o), .drive_i(drv), .drive_en_i(drv_en), .level_o(pad_i));
	always #2.5 ref_clk_i = ~ref_clk_i;
	// ------------------------------------------------------------
	// bus and compare tasks
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk_i);
		reg_write_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge ref_clk_i);
		reg_write_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge ref_clk_i);
		reg_read_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge ref_clk_i);
		reg_read_i <= 1'b0;
		#1 check(reg_rdata_o, exp, "read data");
	endtask : rd
	// settle time after the edge so registered outputs have landed
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : tick
	task automatic wait_rel;
		for (int i = 0; i < 50 && chip_reset_o !== 1'b0; i++) tick(1);
		check(16'(chip_reset_o), 16'h0000, "chip reset");
	endtask : wait_rel
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : complete_run
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		tick(3);
		check(16'(pad_oe_n_o), 16'h007F, "drivers in reset");
		check(16'(pad_pullup_o), 16'h007F, "pull-ups in reset");
		check(16'(chip_reset_o), 16'h0001, "chip reset");
		@(posedge ref_clk_i);
		reset_i <= 1'b0;
		wait_rel();
		rd(pfr_pkg::REG_FUNC_SEL, 16'h0000);
		rd(pfr_pkg::REG_CLOCK_OUTPUT_PIN_SEL, 16'h0000);
		$display("test defaults done");
		// host changes select and data as it drops the test clock, then raises the clock alone
		@(posedge ref_clk_i);
		drv_en <= 7'h70;
		drv <= 7'h50;
		tick(2);
		check({tap_tdi_o, tap_tms_o, tap_tck_o}, 3'b101, "test inputs");
		drv <= 7'h20;
		tick(2);
		check({tap_tdi_o, tap_tms_o, tap_tck_o}, 3'b010, "test inputs");
		// rising test clock while select and data stay where they were
		drv <= 7'h30;
		tick(2);
		check({tap_tdi_o, tap_tms_o, tap_tck_o}, 3'b011, "test inputs");
		wr(pfr_pkg::REG_FUNC_SEL, 16'h01C0);
		tick(2);
		check({tap_tdi_o, tap_tms_o, tap_tck_o}, 3'b111, "test inputs as port");
		$display("test tap done");
		drv_en <= 7'h08;
		drv <= 7'h08;
		wr(pfr_pkg::REG_FUNC_SEL, 16'h0000);
		wr(pfr_pkg::REG_GPIO_DIR, 16'h0005);
		wr(pfr_pkg::REG_GPIO_OUT, 16'h0001);
		tick(2);
		check(16'(pad_oe_n_o), 16'h007A, "directions");
		check({pad_o[2], pad_o[0]}, 2'b01, "port outputs");
		check({b7_alt_in_o, timer0_in_o, timer1_in_o}, 3'b100, "idle peripheral inputs");
		rd(pfr_pkg::REG_GPIO_IN, 16'h007B);
		drv_en <= 7'h00;
		alt <= 1'b1;
		wr(pfr_pkg::REG_FUNC_SEL, 16'h0015);
		tick(2);
		check(16'(pad_oe_n_o), 16'h0072, "alternate drivers");
		check({pad_o[3:2], pad_o[0]}, 3'b111, "alternate outputs");
		check({b7_alt_in_o, timer0_in_o, timer1_in_o}, 3'b111, "peripheral inputs");
		$display("test port done");
		wr(pfr_pkg::REG_FUNC_SEL, 16'h0008);
		for (int s = 0; s < 4; s++) begin
			wr(pfr_pkg::REG_CLOCK_OUTPUT_PIN_SEL, 16'(s));
			src <= (s == 0) ? 3'h7 : 3'(1 << (s - 1));
			tick(4);
			check(16'(pad_o[2]), 16'(s != 0), "clock output");
		end
		$display("test clock output done");
		wr(pfr_pkg::REG_FUNC_SEL, 16'h0020);
		wr(pfr_pkg::REG_FAULT_MASK, 16'h0015);
		rd(pfr_pkg::REG_FAULT_MASK, 16'h0015);
		drv_en <= 7'h08;
		drv <= 7'h08;
		tick(2);
		check(16'(pwm_disable_o), 16'h0015, "pwm disable");
		drv <= 7'h00;
		tick(2);
		check(16'(pwm_disable_o), 16'h0000, "pwm disable");
		$display("test fault done");
		wr(pfr_pkg::REG_FUNC_SEL, 16'h0001);
		drv_en <= 7'h02;
		tick(5);
		check(16'(chip_reset_o), 16'h0001, "pin reset");
		check(16'(pad_oe_n_o), 16'h007F, "drivers in reset");
		drv_en <= 7'h00;
		wait_rel();
		rd(pfr_pkg::REG_FUNC_SEL, 16'h0000);
		// sticky pin reset record survives the chip reset, a read clears it
		rd(pfr_pkg::REG_STATUS, 16'h0002);
		rd(pfr_pkg::REG_STATUS, 16'h0000);
		$display("test pin reset done");
		wr(pfr_pkg::REG_FUNC_SEL, 16'h0002);
		wr(pfr_pkg::REG_GPIO_DIR, 16'h0002);
		tick(2);
		check({pad_oe_n_o[1], pad_o[1]}, 2'b00, "open drain low");
		drv_en <= 7'h02;
		tick(4);
		check(16'(chip_reset_o), 16'h0000, "pin reset ignored");
		wr(pfr_pkg::REG_GPIO_OUT, 16'h0002);
		tick(2);
		check(16'(pad_oe_n_o[1]), 16'h0001, "open drain released");
		// board lets go first: the next reset hands the pin back to reset duty,
		// and a line still held low would then keep the chip in reset for good
		drv_en <= 7'h00;
		for (int k = 0; k < 2; k++) begin
			{software_reset_i, watchdog_reset_i} <= 2'(1 << k);
			tick(2);
			check(16'(chip_reset_o), 16'h0001, "other reset");
			{software_reset_i, watchdog_reset_i} <= 2'b00;
			wait_rel();
			rd(pfr_pkg::REG_FUNC_SEL, 16'h0000);
		end
		$display("test port reset line done");
		complete_run();
	end
	// cut a hang well past the hundred or so cycles the tests need
	initial begin
		#50us;
		error_cnt++;
		complete_run();
	end
endmodule : pin_function_reset_mux_tb
